/* File: core/arm_remap.sv */
// Summary of operation
// - downstream I/O cycles drop the programmed number of upper address bits
// - claim downstream memory only inside primary window base and limit
// - non-prefetchable offset is primary base minus secondary base, subtracted
// - prefetchable offset likewise, subtracted from the primary address
// - secondary window tops are primary limits minus matching offsets
// - never claim secondary cycles inside shifted secondary windows
// - DMA window bounded by secondary base/limit, offset primary minus secondary
// - upstream cycles inside a DMA window gain that window's offset
// - upstream cycles outside all windows pass with address unchanged
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`include "arm_consts.svh"
`default_nettype none
module arm_remap (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  // register bus
  input  wire logic [`ARM_BUS_AW-1:0] awaddr,
  input  wire logic                   awvalid,
  output wire logic                   awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output wire logic                   wready,
  output wire logic [1:0]             bresp,
  output wire logic                   bvalid,
  input  wire logic                   bready,
  input  wire logic [`ARM_BUS_AW-1:0] araddr,
  input  wire logic                   arvalid,
  output wire logic                   arready,
  output wire logic [31:0]            rdata,
  output wire logic [1:0]             rresp,
  output wire logic                   rvalid,
  input  wire logic                   rready,
  // downstream cycles from the primary link
  input  wire logic                   dnValid,
  input  wire logic                   dnIo,
  input  wire arm_pkg::arm_pri_addr_t dnAddr,
  output logic                        dnFwdValid,
  output logic                        dnFwdIo,
  output logic                        dnFwdPf,
  output arm_pkg::arm_sec_addr_t      dnFwdAddr,
  output logic                        dnMiss,
  // upstream memory cycles from the secondary bus
  input  wire logic                   upValid,
  input  wire arm_pkg::arm_sec_addr_t upAddr,
  output logic                        upFwdValid,
  output logic                        upDmaHit,
  output arm_pkg::arm_pri_addr_t      upFwdAddr,
  output logic                        upRefused
);
  arm_cfg_if cfg ();

  arm_axil_regs regs (
    .clock   (clock),
    .reset_n (reset_n),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .cfg     (cfg)
  );

  function automatic logic inRange(input arm_pkg::arm_pri_addr_t a, input arm_pkg::arm_pri_addr_t lo,
                                   input arm_pkg::arm_pri_addr_t hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  // window registers hold address bits 39:8, so windows have 256-byte grain
  function automatic arm_pkg::arm_pri_addr_t winAddr(input logic [7:0] off, input logic [7:0] low);
    winAddr = {cfg.word[arm_pkg::arm_idx_f(off)], low};
  endfunction

  // ****************************************
  // window decode
  // ****************************************
  arm_pkg::arm_word_t     ctrl;
  logic                   enNp;
  logic                   enPf;
  logic                   enIo;
  logic [1:0]             enDma;
  arm_pkg::arm_pri_addr_t npPriBase;
  arm_pkg::arm_pri_addr_t npPriLimit;
  arm_pkg::arm_pri_addr_t npSecBase;
  arm_pkg::arm_pri_addr_t pfPriBase;
  arm_pkg::arm_pri_addr_t pfPriLimit;
  arm_pkg::arm_pri_addr_t pfSecBase;
  arm_pkg::arm_pri_addr_t np_window_offset;
  arm_pkg::arm_pri_addr_t pf_window_offset;
  arm_pkg::arm_pri_addr_t sec_np_top;
  arm_pkg::arm_pri_addr_t sec_pf_top;
  arm_pkg::arm_pri_addr_t dma_sec_base [2];
  arm_pkg::arm_pri_addr_t dma_sec_limit [2];
  arm_pkg::arm_pri_addr_t dma_pri_base [2];
  arm_pkg::arm_pri_addr_t dma_window_offset [2];

  assign ctrl       = cfg.word[arm_pkg::arm_idx_f(`ARM_OFF_CTRL)];
  assign enNp       = ctrl[`ARM_CTRL_EN] && ctrl[`ARM_CTRL_NP_EN];
  assign enPf       = ctrl[`ARM_CTRL_EN] && ctrl[`ARM_CTRL_PF_EN];
  assign enIo       = ctrl[`ARM_CTRL_EN] && ctrl[`ARM_CTRL_IO_EN];
  assign enDma      = {2{ctrl[`ARM_CTRL_EN]}} & {ctrl[`ARM_CTRL_DMA1_EN], ctrl[`ARM_CTRL_DMA0_EN]};
  assign npPriBase  = winAddr(`ARM_OFF_NP_PRI_BASE, `ARM_WIN_LOW_0);
  assign npPriLimit = winAddr(`ARM_OFF_NP_PRI_LIMIT, `ARM_WIN_LOW_1);
  assign npSecBase  = winAddr(`ARM_OFF_NP_SEC_BASE, `ARM_WIN_LOW_0);
  assign pfPriBase  = winAddr(`ARM_OFF_PF_PRI_BASE, `ARM_WIN_LOW_0);
  assign pfPriLimit = winAddr(`ARM_OFF_PF_PRI_LIMIT, `ARM_WIN_LOW_1);
  assign pfSecBase  = winAddr(`ARM_OFF_PF_SEC_BASE, `ARM_WIN_LOW_0);
  // full 40-bit arithmetic, wrap is intended
  assign np_window_offset = npPriBase - npSecBase;
  assign pf_window_offset = pfPriBase - pfSecBase;
  assign sec_np_top       = npPriLimit - np_window_offset;
  assign sec_pf_top       = pfPriLimit - pf_window_offset;

  assign dma_sec_base[0]  = winAddr(`ARM_OFF_DMA0_SEC_BASE, `ARM_WIN_LOW_0);
  assign dma_sec_limit[0] = winAddr(`ARM_OFF_DMA0_SEC_LIMIT, `ARM_WIN_LOW_1);
  assign dma_pri_base[0]  = winAddr(`ARM_OFF_DMA0_PRI_BASE, `ARM_WIN_LOW_0);
  assign dma_sec_base[1]  = winAddr(`ARM_OFF_DMA1_SEC_BASE, `ARM_WIN_LOW_0);
  assign dma_sec_limit[1] = winAddr(`ARM_OFF_DMA1_SEC_LIMIT, `ARM_WIN_LOW_1);
  assign dma_pri_base[1]  = winAddr(`ARM_OFF_DMA1_PRI_BASE, `ARM_WIN_LOW_0);
  assign dma_window_offset[0] = dma_pri_base[0] - dma_sec_base[0];
  assign dma_window_offset[1] = dma_pri_base[1] - dma_sec_base[1];

  // ****************************************
  // downstream path
  // ****************************************
  arm_pkg::arm_pri_addr_t ioBase;
  arm_pkg::arm_pri_addr_t ioLimit;
  logic [`ARM_IO_SIZE_W-1:0] ioSize;
  logic [`ARM_IO_AW-1:0]  ioMask;
  logic                   ioHit;
  logic                   npHit;
  logic                   pfHit;
  arm_pkg::arm_pri_addr_t memSecAddr;
  arm_pkg::arm_sec_addr_t dnNext;

  assign ioBase     = {15'h0000, cfg.word[arm_pkg::arm_idx_f(`ARM_OFF_IO_BASE)][`ARM_IO_AW-1:0]};
  assign ioLimit    = {15'h0000, cfg.word[arm_pkg::arm_idx_f(`ARM_OFF_IO_LIMIT)][`ARM_IO_AW-1:0]};
  assign ioSize     = cfg.word[arm_pkg::arm_idx_f(`ARM_OFF_IO_SIZE)][`ARM_IO_SIZE_W-1:0];
  assign ioMask     = {`ARM_IO_AW{1'b1}} >> ioSize;
  assign ioHit      = enIo && dnIo && inRange(dnAddr, ioBase, ioLimit);
  assign npHit      = enNp && !dnIo && inRange(dnAddr, npPriBase, npPriLimit);
  assign pfHit      = enPf && !dnIo && !npHit && inRange(dnAddr, pfPriBase, pfPriLimit);
  assign memSecAddr = dnAddr - (npHit ? np_window_offset : pf_window_offset);
  // I/O window keeps only the low bits the secondary bus decodes
  assign dnNext     = ioHit ? {7'h00, dnAddr[`ARM_IO_AW-1:0] & ioMask} : memSecAddr[31:0];

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dnFwdValid <= 1'b0;
      dnFwdIo    <= 1'b0;
      dnFwdPf    <= 1'b0;
      dnFwdAddr  <= 32'h0000_0000;
      dnMiss     <= 1'b0;
    end
    else
    begin
      dnFwdValid <= dnValid && (ioHit || npHit || pfHit);
      dnFwdIo    <= ioHit;
      dnFwdPf    <= pfHit;
      dnFwdAddr  <= dnNext;
      dnMiss     <= dnValid && !(ioHit || npHit || pfHit);
    end
  end

  // ****************************************
  // upstream path
  // ****************************************
  arm_pkg::arm_pri_addr_t upExt;
  logic                   inSecWin;
  logic [1:0]             dmaHit;
  arm_pkg::arm_pri_addr_t upNext;

  assign upExt    = {8'h00, upAddr};
  assign inSecWin = (enNp && inRange(upExt, npSecBase, sec_np_top)) ||
                    (enPf && inRange(upExt, pfSecBase, sec_pf_top));
  assign dmaHit[0] = enDma[0] && inRange(upExt, dma_sec_base[0], dma_sec_limit[0]);
  assign dmaHit[1] = enDma[1] && inRange(upExt, dma_sec_base[1], dma_sec_limit[1]);
  // window 0 wins if software lets the two overlap
  assign upNext = dmaHit[0] ? upExt + dma_window_offset[0] :
                  dmaHit[1] ? upExt + dma_window_offset[1] : upExt;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      upFwdValid <= 1'b0;
      upDmaHit   <= 1'b0;
      upFwdAddr  <= 40'h00_0000_0000;
      upRefused  <= 1'b0;
    end
    else
    begin
      upFwdValid <= upValid && !inSecWin;
      upDmaHit   <= |dmaHit;
      upFwdAddr  <= upNext;
      upRefused  <= upValid && inSecWin;
    end
  end

  // legacy decode bits are only stored and ORed into status bit 6; software keeps them clear
  assign cfg.status = {25'h000_0000, ctrl[`ARM_CTRL_LEG_BUS] | ctrl[`ARM_CTRL_LEG_DISP],
                       upDmaHit, upRefused, upFwdValid, dnFwdPf, dnMiss, dnFwdValid};

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  io_alias_a: assert property (dnValid && ioHit |=> dnFwdValid && dnFwdIo &&
    ((dnFwdAddr[`ARM_IO_AW-1:0] & ~($past(ioMask))) == 25'h000_0000)) else $error("io alias bits kept");
  claim_window_a: assert property (dnValid && !dnIo && !npHit && !pfHit |=> !dnFwdValid && dnMiss)
    else $error("memory cycle claimed outside window");
  np_offset_a: assert property (dnFwdValid && !dnFwdIo && !dnFwdPf && $stable(np_window_offset) |->
    (dnFwdAddr + np_window_offset[31:0]) == $past(dnAddr[31:0])) else $error("np offset wrong");
  pf_offset_a: assert property (dnFwdValid && dnFwdPf && $stable(pf_window_offset) |->
    (dnFwdAddr + pf_window_offset[31:0]) == $past(dnAddr[31:0])) else $error("pf offset wrong");
  sec_top_a: assert property ((sec_np_top - npSecBase) == (npPriLimit - npPriBase) &&
    (sec_pf_top - pfSecBase) == (pfPriLimit - pfPriBase)) else $error("secondary top wrong");
  sec_refuse_a: assert property (upValid && enNp && inRange(upExt, npSecBase, sec_np_top) |=>
    upRefused && !upFwdValid) else $error("shifted window claimed");
  dma_fwd_a: assert property (upValid && !inSecWin && dmaHit[0] && $stable(dma_window_offset[0]) |=>
    upFwdValid && upDmaHit && (upFwdAddr - {8'h00, $past(upAddr)}) == $past(dma_window_offset[0]))
    else $error("dma offset wrong");
  pass_through_a: assert property (upFwdValid && !upDmaHit |->
    upFwdAddr == {8'h00, $past(upAddr)}) else $error("address modified");
  zero_offset_a: assert property (dnValid && npHit && npPriBase == npSecBase |=>
    dnFwdAddr == $past(dnAddr[31:0])) else $error("zero offset changed address");

  io_fwd_c: cover property (dnValid && ioHit ##1 dnFwdValid);
  pf_fwd_c: cover property (dnValid && pfHit ##1 dnFwdValid && dnFwdPf);
  dma_fwd_c: cover property (upValid && dmaHit[1] && !dmaHit[0] ##1 upFwdValid);
  refuse_c: cover property (upValid && inSecWin ##1 upRefused);
endmodule
`default_nettype wire

/* File: core/arm_consts.svh */
`ifndef ARM_CONSTS_SVH
`define ARM_CONSTS_SVH

// ****************************************
// widths
// ****************************************
`define ARM_PRI_AW      40
`define ARM_SEC_AW      32
`define ARM_IO_AW       25
`define ARM_BUS_AW      8
`define ARM_REG_NUM     18
`define ARM_IO_SIZE_W   5
`define ARM_WIN_LOW_0   8'h00
`define ARM_WIN_LOW_1   8'hFF

// ****************************************
// register byte offsets
// ****************************************
`define ARM_OFF_CTRL         8'h00
`define ARM_OFF_STATUS       8'h04
`define ARM_OFF_IO_BASE      8'h08
`define ARM_OFF_IO_LIMIT     8'h0C
`define ARM_OFF_IO_SIZE      8'h10
`define ARM_OFF_NP_PRI_BASE  8'h14
`define ARM_OFF_NP_PRI_LIMIT 8'h18
`define ARM_OFF_NP_SEC_BASE  8'h1C
`define ARM_OFF_PF_PRI_BASE  8'h20
`define ARM_OFF_PF_PRI_LIMIT 8'h24
`define ARM_OFF_PF_SEC_BASE  8'h28
`define ARM_OFF_DMA0_SEC_BASE  8'h2C
`define ARM_OFF_DMA0_SEC_LIMIT 8'h30
`define ARM_OFF_DMA0_PRI_BASE  8'h34
`define ARM_OFF_DMA1_SEC_BASE  8'h38
`define ARM_OFF_DMA1_SEC_LIMIT 8'h3C
`define ARM_OFF_DMA1_PRI_BASE  8'h40

// ****************************************
// control fields, reset values, responses
// ****************************************
`define ARM_CTRL_EN       0
`define ARM_CTRL_NP_EN    1
`define ARM_CTRL_PF_EN    2
`define ARM_CTRL_IO_EN    3
`define ARM_CTRL_DMA0_EN  4
`define ARM_CTRL_DMA1_EN  5
`define ARM_CTRL_LEG_DISP 6
`define ARM_CTRL_LEG_BUS  7
`define ARM_REG_RST       32'h0000_0000
`define ARM_RESP_OKAY     2'h0
`define ARM_RESP_SLVERR   2'h2

`endif

/* File: core/arm_pkg.sv */
`default_nettype none
package arm_pkg;
  typedef logic [31:0] arm_word_t;
  typedef logic [39:0] arm_pri_addr_t;
  typedef logic [31:0] arm_sec_addr_t;

  function automatic logic [4:0] arm_idx_f(input logic [7:0] off);
    arm_idx_f = off[6:2];
  endfunction
endpackage
`default_nettype wire

/* File: core/arm_cfg_if.sv */
`default_nettype none
interface arm_cfg_if;
  arm_pkg::arm_word_t word [0:17];
  arm_pkg::arm_word_t status;
  modport regs (output word, input status);
  modport core (input word, output status);
endinterface
`default_nettype wire

/* File: core/arm_axil_regs.sv */
`include "arm_consts.svh"
`default_nettype none
module arm_axil_regs (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     reset_n,
  // write channels
  input  wire logic [`ARM_BUS_AW-1:0]   awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  // read channels
  input  wire logic [`ARM_BUS_AW-1:0]   araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  // configuration to the core
  arm_cfg_if.regs                       cfg
);
  logic [`ARM_BUS_AW-1:0] awAddr_reg;
  logic [31:0]            wData_reg;
  logic [3:0]             wStrb_reg;
  logic [4:0]             wIdx;
  logic [4:0]             rIdx;
  logic                   wMapped;
  logic                   wWritable;
  logic                   rMapped;
  logic                   doWrite;
  arm_pkg::arm_word_t     rWord;

  // ****************************************
  // decode
  // ****************************************
  assign wIdx      = arm_pkg::arm_idx_f(awAddr_reg);
  assign rIdx      = arm_pkg::arm_idx_f(araddr);
  assign wMapped   = (awAddr_reg[7] == 1'b0) && (wIdx < 5'(`ARM_REG_NUM));
  assign wWritable = wMapped && (wIdx != arm_pkg::arm_idx_f(`ARM_OFF_STATUS));
  assign rMapped   = (araddr[7] == 1'b0) && (rIdx < 5'(`ARM_REG_NUM));
  assign rWord     = (rIdx == arm_pkg::arm_idx_f(`ARM_OFF_STATUS)) ? cfg.status : cfg.word[rIdx];
  assign doWrite   = !awready && !wready && !bvalid;

  // ****************************************
  // write path: address and data in either order
  // ****************************************
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      bvalid     <= 1'b0;
      bresp      <= `ARM_RESP_OKAY;
      awAddr_reg <= 8'h00;
      wData_reg  <= 32'h0000_0000;
      wStrb_reg  <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awAddr_reg <= awaddr;
        awready    <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
        wready    <= 1'b0;
      end
      if (doWrite)
      begin
        bvalid <= 1'b1;
        bresp  <= wMapped ? `ARM_RESP_OKAY : `ARM_RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // status slot is read-only; writes to it are dropped with OKAY
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < `ARM_REG_NUM; i++)
      begin
        cfg.word[i] <= `ARM_REG_RST;
      end
    end
    else if (doWrite && wWritable)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wStrb_reg[b])
        begin
          cfg.word[wIdx][b*8 +: 8] <= wData_reg[b*8 +: 8];
        end
      end
    end
  end

  // ****************************************
  // read path: one cycle after the address
  // ****************************************
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `ARM_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rMapped ? rWord : 32'h0000_0000;
      rresp   <= rMapped ? `ARM_RESP_OKAY : `ARM_RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: dv/arm_far_model.sv */
`default_nettype none
module arm_far_model (
  // clock
  input  wire logic                   clock,
  // upstream memory cycles toward the bridge
  output var  logic                   upValid,
  output var  arm_pkg::arm_sec_addr_t upAddr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    upValid = 1'b0;
    upAddr  = 32'h0000_0000;
  end

  // idle address is inverted so a stale value is never mistaken for a live one
  task automatic up_cycle(input arm_pkg::arm_sec_addr_t a);
    @(posedge clock);
    upValid <= 1'b1;
    upAddr  <= a;
    @(posedge clock);
    upValid <= 1'b0;
    upAddr  <= ~a;
    #1;
  endtask
endmodule
`default_nettype wire

/* File: dv/bridge_address_remapper_tb_top.sv */
`include "arm_consts.svh"
`default_nettype none
module bridge_address_remapper_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clock, reset_n;
  logic [7:0]             awaddr, araddr;
  logic [31:0]            wdata, rdata;
  logic [3:0]             wstrb;
  logic [1:0]             bresp, rresp;
  logic                   awvalid, awready, wvalid, wready, bvalid, bready;
  logic                   arvalid, arready, rvalid, rready;
  logic                   dnValid, dnIo, dnFwdValid, dnFwdIo, dnFwdPf, dnMiss;
  logic                   upValid, upFwdValid, upDmaHit, upRefused;
  arm_pkg::arm_pri_addr_t dnAddr, upFwdAddr;
  arm_pkg::arm_sec_addr_t dnFwdAddr, upAddr;
  int                     fails, samplesChecked;
  localparam logic [39:0] npOff   = 40'h08_8000_0000 - 40'h00_0000_0000;
  localparam logic [39:0] pfOff   = 40'h09_C000_0000 - 40'h00_C000_0000;
  localparam logic [39:0] dma0Off = 40'h0C_C000_0000 - 40'h00_4000_0000;
  localparam logic [39:0] dma1Off = 40'h0C_8000_0000 - 40'h00_8000_0000;
  logic [7:0]  cfgOff [16] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24,
                               8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h00};
  logic [31:0] cfgVal [16] = '{32'h0010_0000, 32'h0017_FFFF, 32'h0000_0006, 32'h0880_0000,
                               32'h08BF_FFFF, 32'h0000_0000, 32'h09C0_0000, 32'h0AFF_FFFF,
                               32'h00C0_0000, 32'h0040_0000, 32'h007F_FFFF, 32'h0CC0_0000,
                               32'h0080_0000, 32'h00BF_FFFF, 32'h0C80_0000, 32'h0000_003F};

  arm_remap i_arm_remap (
    .clock(clock), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .dnValid(dnValid), .dnIo(dnIo), .dnAddr(dnAddr),
    .dnFwdValid(dnFwdValid), .dnFwdIo(dnFwdIo), .dnFwdPf(dnFwdPf), .dnFwdAddr(dnFwdAddr),
    .dnMiss(dnMiss), .upValid(upValid), .upAddr(upAddr), .upFwdValid(upFwdValid),
    .upDmaHit(upDmaHit), .upFwdAddr(upFwdAddr), .upRefused(upRefused));

  arm_far_model i_arm_far_model (.clock(clock), .upValid(upValid), .upAddr(upAddr));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ****
  // reporting
  // ****
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic hang();
    fails++;
    $display("BAD handshake expected done seen hang");
    finish_test();
  endtask

  // ****
  // register bus master
  // ****
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic bDone;
    bDone = 1'b0;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int i = 0; i < 40 && !bDone; i++)
    begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        bDone = 1'b1;
        chk("bresp", {38'h0, er}, {38'h0, bresp});
      end
    end
    bready <= 1'b0;
    if (!bDone) hang();
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic rDone;
    rDone = 1'b0;
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int i = 0; i < 40 && !rDone; i++)
    begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        rDone = 1'b1;
        chk("rdata", {8'h00, ed}, {8'h00, rdata});
        chk("rresp", {38'h0, er}, {38'h0, rresp});
      end
    end
    rready <= 1'b0;
    if (!rDone) hang();
  endtask

  // ****
  // cycle drivers
  // ****
  task automatic dn_chk(input logic io, input logic fw, input logic pf, input logic [39:0] ea);
    chk("dnFwdValid", {39'h0, fw}, {39'h0, dnFwdValid});
    chk("dnMiss", {39'h0, !fw}, {39'h0, dnMiss});
    if (fw)
    begin
      chk("dnFwdIo", {39'h0, io}, {39'h0, dnFwdIo});
      chk("dnFwdPf", {39'h0, pf}, {39'h0, dnFwdPf});
      chk("dnFwdAddr", {8'h00, ea[31:0]}, {8'h00, dnFwdAddr});
    end
  endtask

  task automatic dn(input logic io, input logic [39:0] a, input logic fw, input logic pf, input logic [39:0] ea);
    @(posedge clock);
    dnValid <= 1'b1;
    dnIo    <= io;
    dnAddr  <= a;
    @(posedge clock);
    dnValid <= 1'b0;
    dnAddr  <= ~a;
    #1;
    dn_chk(io, fw, pf, ea);
  endtask

  task automatic up(input logic [31:0] a, input logic fw, input logic hit, input logic [39:0] ea);
    i_arm_far_model.up_cycle(a);
    chk("upFwdValid", {39'h0, fw}, {39'h0, upFwdValid});
    chk("upRefused", {39'h0, !fw}, {39'h0, upRefused});
    if (fw)
    begin
      chk("upDmaHit", {39'h0, hit}, {39'h0, upDmaHit});
      chk("upFwdAddr", ea, upFwdAddr);
    end
  endtask

  // ****
  // main sequence
  // ****
  initial
  begin
    reset_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, dnValid, dnIo} = '0;
    {awaddr, araddr, wstrb, wdata, dnAddr} = '0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    for (int k = 0; k < 17; k++) axi_rd(8'(4 * k), `ARM_REG_RST, `ARM_RESP_OKAY);
    axi_rd(8'h48, 32'h0000_0000, `ARM_RESP_SLVERR);
    axi_wr(8'h48, 32'hFFFF_FFFF, 4'hF, `ARM_RESP_SLVERR);
    axi_wr(`ARM_OFF_STATUS, 32'hFFFF_FFFF, 4'hF, `ARM_RESP_OKAY);
    axi_rd(`ARM_OFF_STATUS, 32'h0000_0000, `ARM_RESP_OKAY);
    axi_wr(`ARM_OFF_DMA1_PRI_BASE, 32'hAABB_CCDD, 4'hF, `ARM_RESP_OKAY);
    axi_wr(`ARM_OFF_DMA1_PRI_BASE, 32'h1122_3344, 4'h2, `ARM_RESP_OKAY);
    axi_rd(`ARM_OFF_DMA1_PRI_BASE, 32'hAABB_33DD, `ARM_RESP_OKAY);
    dn(1'b0, 40'h08_8000_1234, 1'b0, 1'b0, 40'h0);
    up(32'h1000_0000, 1'b1, 1'b0, 40'h00_1000_0000);
    $display("test registers done");
    // disjoint windows on both buses, legacy decode bits left clear
    for (int k = 0; k < 16; k++) axi_wr(cfgOff[k], cfgVal[k], 4'hF, `ARM_RESP_OKAY);
    for (int k = 0; k < 16; k++) axi_rd(cfgOff[k], cfgVal[k], `ARM_RESP_OKAY);
    foreach (cfgVal[k])
    begin
      if (k < 3)
      begin
        axi_wr(`ARM_OFF_IO_SIZE, 32'(k * 3), 4'hF, `ARM_RESP_OKAY);
        dn(1'b1, 40'h17_ABCD, 1'b1, 1'b0, 40'h17_ABCD & (40'h1FF_FFFF >> (k * 3)));
      end
    end
    dn(1'b1, 40'h18_0000, 1'b0, 1'b0, 40'h0);
    $display("test io done");
    dn(1'b0, 40'h08_8000_0000, 1'b1, 1'b0, 40'h08_8000_0000 - npOff);
    dn(1'b0, 40'h08_BFFF_FFFF, 1'b1, 1'b0, 40'h08_BFFF_FFFF - npOff);
    dn(1'b0, 40'h08_7FFF_FFFF, 1'b0, 1'b0, 40'h0);
    dn(1'b0, 40'h0A_FFFF_FFFF, 1'b1, 1'b1, 40'h0A_FFFF_FFFF - pfOff);
    dn(1'b0, 40'h0B_0000_0000, 1'b0, 1'b0, 40'h0);
    // back-to-back claims, one per edge
    @(posedge clock);
    dnValid <= 1'b1;
    dnIo    <= 1'b0;
    dnAddr  <= 40'h08_8000_0040;
    @(posedge clock);
    dnAddr  <= 40'h09_C000_0080;
    #1;
    dn_chk(1'b0, 1'b1, 1'b0, 40'h08_8000_0040 - npOff);
    @(posedge clock);
    dnValid <= 1'b0;
    #1;
    dn_chk(1'b0, 1'b1, 1'b1, 40'h09_C000_0080 - pfOff);
    $display("test memory done");
    up(32'h0000_0000, 1'b0, 1'b0, 40'h0);
    up(32'h3FFF_FFFF, 1'b0, 1'b0, 40'h0);
    up(32'hC000_0000, 1'b0, 1'b0, 40'h0);
    up(32'h4000_0000, 1'b1, 1'b1, 40'h00_4000_0000 + dma0Off);
    up(32'h7FFF_FFFF, 1'b1, 1'b1, 40'h00_7FFF_FFFF + dma0Off);
    up(32'h8000_0010, 1'b1, 1'b1, 40'h00_8000_0010 + dma1Off);
    axi_wr(`ARM_OFF_CTRL, 32'h0000_001F, 4'hF, `ARM_RESP_OKAY);
    up(32'h8000_0010, 1'b1, 1'b0, 40'h00_8000_0010);
    $display("test upstream done");
    // equal bases on both buses: claimed cycle keeps its low address bits
    axi_wr(`ARM_OFF_NP_SEC_BASE, 32'h0880_0000, 4'hF, `ARM_RESP_OKAY);
    dn(1'b0, 40'h08_8000_1234, 1'b1, 1'b0, 40'h08_8000_1234);
    // legacy decode bit is only stored and reported in status
    axi_wr(`ARM_OFF_CTRL, 32'h0000_0080, 4'hF, `ARM_RESP_OKAY);
    axi_rd(`ARM_OFF_STATUS, 32'h0000_0040, `ARM_RESP_OKAY);
    $display("test zero offset and legacy done");
    finish_test();
  end
endmodule
`default_nettype wire
